//--- core/cmoh_pkg.sv
package cmoh_pkg;
  // object count and the object-number range used by command requests
  localparam int NOBJ = 32;
  // register byte offsets inside one interface set; the second set sits at IF_BASE2
  localparam logic [11:0] OFF_CMSK = 12'h000;
  localparam logic [11:0] OFF_CRQ = 12'h004;
  localparam logic [11:0] OFF_MSK = 12'h008;
  localparam logic [11:0] OFF_ARB = 12'h00c;
  localparam logic [11:0] OFF_MCTL = 12'h010;
  localparam logic [11:0] OFF_DA = 12'h014;
  localparam logic [11:0] OFF_DB = 12'h018;
  localparam logic [11:0] IF_BASE2 = 12'h040;
  // read-only summary vectors, one bit per object
  localparam logic [11:0] OFF_TXRQ = 12'h080;
  localparam logic [11:0] OFF_NEW_DATA_FLAG = 12'h084;
  localparam logic [11:0] OFF_IRQ_PENDING = 12'h088;
  localparam logic [11:0] OFF_VALID = 12'h08c;
  // command mask bits
  localparam int CM_WR = 7;
  localparam int CM_MASK = 6;
  localparam int CM_ARB = 5;
  localparam int CM_CTRL = 4;
  localparam int CM_CLRINT = 3;
  localparam int CM_TXND = 2;
  localparam int CM_DA = 1;
  localparam int CM_DB = 0;
  localparam logic [7:0] CMSK_RD_ALL = 8'h7f;
  // command request busy flag position
  localparam int CRQ_BUSY = 15;
  // arbitration word: valid, extended, direction, identifier 28:0
  localparam int ARB_VALID = 31;
  localparam int ARB_XTD = 30;
  localparam int ARB_DIR = 29;
  localparam int STD_LO = 18;
  // mask word: extended mask, direction mask, identifier mask 28:0
  localparam int MSK_MASK_EXTENDED_FLAG = 31;
  localparam int MSK_MASK_DIRECTION_FLAG = 30;
  // message control word
  localparam int CTL_NEW_DATA_FLAG = 15;
  localparam int CTL_MESSAGE_LOST = 14;
  localparam int CTL_IRQ_PENDING = 13;
  localparam int CTL_USE_MASK = 12;
  localparam int CTL_TX_IRQ_ENABLE = 11;
  localparam int CTL_RX_IRQ_ENABLE = 10;
  localparam int CTL_REMOTE_ANSWER_ENABLE = 9;
  localparam int CTL_TRANSMIT_REQUEST = 8;
  localparam int CTL_EOB = 7;
  // reset values
  localparam logic [31:0] RST_ARB = 32'h0000_0000;
  localparam logic [31:0] RST_MSK = 32'h1fff_ffff;
  localparam logic [15:0] RST_CTL = 16'h0000;
  localparam logic [7:0] RST_CMSK = 8'h00;
  localparam logic [63:0] RST_DAT = 64'h0000_0000_0000_0000;
  // receive scan states
  typedef enum logic [1:0] {
    SC_IDLE = 2'b01,
    SC_RUN = 2'b10
  } cmoh_scan_t;
endpackage

//--- core/cmoh_top.sv
// Contract
// - standard identifiers use id bits 28:18 only; bits 17:0 are ignored.
// - transmit irq enable set means irq pending rises after a good transmission.
// - remote answer enable lets a matching remote frame request a data reply.
// - use_mask applies identifier, extended and direction masks during matching.
// - data bytes of a transmit object may be updated at any time.
// - write, new-data and data selects then request number update data and request.
// - new data with request keeps request at old end; new data clears at start.
// - scan valid objects from object 1 upward, stop at first match or end.
// - accepted data frame stores data, arbitration, length code and sets new data.
// - storing into an object with new data set raises message lost.
// - receive irq enable sets irq pending when a data frame is stored.
// - remote frame, transmit object, answer enabled: set only transmit request.
// - remote frame, transmit object, no answer, no mask: ignore completely.
// - remote frame, no answer, mask used: clear request, store header, new data.
// - lowest-numbered object with a pending request is sent first.
// - storing a standard-identifier data frame zeroes identifier bits 17:0.
// - eight data bytes are always stored; bytes past length are unspecified.
// - mask 0x7f then a request copies the object, clears new data and pending.
// - message lost is cleared only by software writes.
// - receive object request sends remote frame; cleared if data arrives first.
// - free shift register and no interface transfer load lowest-numbered pending object; the code also waits for an idle receive scan.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
module cmoh_top
  import cmoh_pkg::*;
(
  input wire logic pclk, // module clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic rx_valid, // one-cycle: frame header and data ready
  input wire logic [28:0] rx_id, // received identifier
  input wire logic rx_xtd, // received extended flag
  input wire logic rx_rtr, // received remote flag
  input wire logic [3:0] rx_dlc, // received length code
  input wire logic [63:0] rx_data, // received data bytes
  input wire logic tx_free, // transmit shift register can be loaded
  input wire logic tx_done, // one-cycle: last loaded frame sent ok
  output logic tx_load, // one-cycle: transmit fields valid
  output logic [28:0] tx_id, // transmit identifier
  output logic tx_xtd, // transmit extended flag
  output logic tx_rtr, // transmit remote flag
  output logic [3:0] tx_dlc, // transmit length code
  output logic [63:0] tx_data, // transmit data bytes
  output logic [4:0] tx_obj, // object index being sent
  output logic [31:0] irq_pending_vec // per-object pending flags
);

  // message memory
  logic [31:0] obj_arb_r [NOBJ];
  logic [31:0] obj_msk_r [NOBJ];
  logic [15:0] obj_ctl_r [NOBJ];
  logic [63:0] obj_dat_r [NOBJ];
  // interface register sets
  logic [7:0] cmsk_r [2];
  logic [5:0] crq_r [2];
  logic [1:0] busy_r;
  logic [31:0] msk_r [2];
  logic [31:0] arb_r [2];
  logic [15:0] ctl_r [2];
  logic [31:0] da_r [2];
  logic [31:0] db_r [2];
  logic [4:0] if_idx [2];
  logic [1:0] crq_ok;
  // receive scan
  cmoh_scan_t scan_st_r;
  logic [4:0] sc_idx_r;
  logic [28:0] f_id_r;
  logic f_xtd_r;
  logic f_rtr_r;
  logic [3:0] f_dlc_r;
  logic [63:0] f_data_r;
  // transmit side
  logic txd_pend_r;
  logic tx_load_r;
  logic [4:0] txobj_r;
  logic [31:0] pend_vec, new_data_flag_vec, valid_vec;
  logic tx_hit;
  logic [4:0] tx_sel;
  // memory access grants
  logic gnt_txd, gnt_scan, gnt_txl;
  logic [1:0] gnt_if;
  logic e_gi;
  logic [4:0] e_idx;
  logic [7:0] e_cm;
  logic hit, act_data, act_ans, act_rst, act_ign;
  logic wr_en;
  logic [31:0] rd_val;

  // objects match on arbitration bits under the optional mask
  function automatic logic obj_match(input logic [31:0] arb, input logic [31:0] msk,
                                     input logic [15:0] ctl, input logic [28:0] fid,
                                     input logic fxtd, input logic frtr);
    logic [28:0] idm;
    logic um, xm, dm;
    um = ctl[CTL_USE_MASK];
    idm = um ? msk[28:0] : 29'h1fff_ffff;
    if (!fxtd) begin
      idm[STD_LO-1:0] = 18'h0;
    end
    xm = !um || msk[MSK_MASK_EXTENDED_FLAG];
    dm = !um || msk[MSK_MASK_DIRECTION_FLAG];
    obj_match = arb[ARB_VALID] && (((arb[28:0] ^ fid) & idm) == 29'h0) &&
                (!xm || (arb[ARB_XTD] == fxtd)) && (!dm || (arb[ARB_DIR] == frtr));
  endfunction

  // decode used by the error answer only; the read path decodes paddr in its own case
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a[1:0] == 2'b00) &&
              (((a[11:7] == 5'h0) && (a[5:0] <= OFF_DB[5:0])) ||
               ((a[11:4] == OFF_TXRQ[11:4]) && (a[3:0] <= OFF_VALID[3:0])));
  endfunction

  // per-object summary vectors
  genvar i;
  generate
    for (i = 0; i < NOBJ; i++) begin : g_vec
      assign pend_vec[i] = obj_arb_r[i][ARB_VALID] && obj_ctl_r[i][CTL_TRANSMIT_REQUEST];
      assign new_data_flag_vec[i] = obj_ctl_r[i][CTL_NEW_DATA_FLAG];
      assign valid_vec[i] = obj_arb_r[i][ARB_VALID];
      assign irq_pending_vec[i] = obj_ctl_r[i][CTL_IRQ_PENDING];
    end
  endgenerate

  // lowest index wins regardless of identifier
  always_comb begin
    tx_hit = 1'b0;
    tx_sel = 5'h00;
    for (int k = NOBJ - 1; k >= 0; k--) begin
      if (pend_vec[k]) begin
        tx_hit = 1'b1;
        tx_sel = 5'(k);
      end
    end
  end

  // one memory user per cycle; completions first so none is lost
  assign gnt_txd = txd_pend_r;
  assign gnt_if[0] = !gnt_txd && busy_r[0];
  assign gnt_if[1] = !gnt_txd && !busy_r[0] && busy_r[1];
  assign gnt_scan = !gnt_txd && (busy_r == 2'b00) && (scan_st_r == SC_RUN);
  assign gnt_txl = !gnt_txd && (busy_r == 2'b00) && (scan_st_r == SC_IDLE) &&
                   tx_free && !tx_load_r && tx_hit;
  assign e_gi = gnt_if[1];
  assign e_idx = if_idx[e_gi];
  assign e_cm = cmsk_r[e_gi];

  // frame classification for the object under the scan pointer
  assign hit = gnt_scan && obj_match(obj_arb_r[sc_idx_r], obj_msk_r[sc_idx_r],
                                     obj_ctl_r[sc_idx_r], f_id_r, f_xtd_r, f_rtr_r);
  assign act_data = hit && !f_rtr_r;
  assign act_ans = hit && f_rtr_r && obj_arb_r[sc_idx_r][ARB_DIR] &&
                   obj_ctl_r[sc_idx_r][CTL_REMOTE_ANSWER_ENABLE];
  assign act_rst = hit && f_rtr_r && obj_arb_r[sc_idx_r][ARB_DIR] &&
                   !obj_ctl_r[sc_idx_r][CTL_REMOTE_ANSWER_ENABLE] && obj_ctl_r[sc_idx_r][CTL_USE_MASK];
  assign act_ign = hit && !act_data && !act_ans && !act_rst;

  // apb slave: zero wait states, error only on unmapped words
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);

  // interface register sets; software writes are held off while a set is busy
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ifs
      logic if_hit;
      assign if_hit = wr_en && (paddr[11:7] == 5'h0) && (paddr[6] == 1'(g)) && !busy_r[g];
      assign crq_ok[g] = (crq_r[g] != 6'h00) && (crq_r[g] <= 6'(NOBJ));
      assign if_idx[g] = 5'(crq_r[g] - 6'h01);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmsk_r[g] <= RST_CMSK;
          crq_r[g] <= 6'h01;
          busy_r[g] <= 1'b0;
          msk_r[g] <= RST_MSK;
          arb_r[g] <= RST_ARB;
          ctl_r[g] <= RST_CTL;
          da_r[g] <= 32'h0000_0000;
          db_r[g] <= 32'h0000_0000;
        end else if (gnt_if[g]) begin
          busy_r[g] <= 1'b0;
          // read transfer copies the object image taken before the clears
          if (!cmsk_r[g][CM_WR] && crq_ok[g]) begin
            if (cmsk_r[g][CM_MASK]) begin
              msk_r[g] <= obj_msk_r[if_idx[g]];
            end
            if (cmsk_r[g][CM_ARB]) begin
              arb_r[g] <= obj_arb_r[if_idx[g]];
            end
            if (cmsk_r[g][CM_CTRL]) begin
              ctl_r[g] <= obj_ctl_r[if_idx[g]];
            end
            if (cmsk_r[g][CM_DA]) begin
              da_r[g] <= obj_dat_r[if_idx[g]][31:0];
            end
            if (cmsk_r[g][CM_DB]) begin
              db_r[g] <= obj_dat_r[if_idx[g]][63:32];
            end
          end
        end else if (if_hit) begin
          case (paddr[5:0])
            OFF_CMSK[5:0]: cmsk_r[g] <= pwdata[7:0];
            OFF_CRQ[5:0]: begin
              crq_r[g] <= pwdata[5:0];
              busy_r[g] <= 1'b1;
            end
            OFF_MSK[5:0]: msk_r[g] <= pwdata;
            OFF_ARB[5:0]: arb_r[g] <= pwdata;
            OFF_MCTL[5:0]: ctl_r[g] <= pwdata[15:0];
            OFF_DA[5:0]: da_r[g] <= pwdata;
            OFF_DB[5:0]: db_r[g] <= pwdata;
            default: ;
          endcase
        end
      end
    end
  endgenerate

  // message memory writer; at most one grant is served per cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < NOBJ; k++) begin
        obj_arb_r[k] <= RST_ARB;
        obj_msk_r[k] <= RST_MSK;
        obj_ctl_r[k] <= RST_CTL;
        obj_dat_r[k] <= RST_DAT;
      end
    end else if (gnt_txd) begin
      // new data written since the start keeps the request alive
      if (!obj_ctl_r[txobj_r][CTL_NEW_DATA_FLAG]) begin
        obj_ctl_r[txobj_r][CTL_TRANSMIT_REQUEST] <= 1'b0;
      end
      if (obj_ctl_r[txobj_r][CTL_TX_IRQ_ENABLE]) begin
        obj_ctl_r[txobj_r][CTL_IRQ_PENDING] <= 1'b1;
      end
    end else if (gnt_if != 2'b00) begin
      if (!crq_ok[e_gi]) begin
        // bad object number: transfer is dropped
      end else if (e_cm[CM_WR]) begin
        // no valid or request check: data may change at any time
        if (e_cm[CM_MASK]) begin
          obj_msk_r[e_idx] <= msk_r[e_gi];
        end
        if (e_cm[CM_ARB]) begin
          obj_arb_r[e_idx] <= arb_r[e_gi];
        end
        if (e_cm[CM_CTRL]) begin
          obj_ctl_r[e_idx] <= ctl_r[e_gi];
        end
        obj_dat_r[e_idx] <= {e_cm[CM_DB] ? db_r[e_gi] : obj_dat_r[e_idx][63:32],
                             e_cm[CM_DA] ? da_r[e_gi] : obj_dat_r[e_idx][31:0]};
        if (e_cm[CM_TXND]) begin
          obj_ctl_r[e_idx][CTL_TRANSMIT_REQUEST] <= 1'b1;
          obj_ctl_r[e_idx][CTL_NEW_DATA_FLAG] <= 1'b1;
        end
      end else begin
        if (e_cm[CM_CLRINT]) begin
          obj_ctl_r[e_idx][CTL_IRQ_PENDING] <= 1'b0;
        end
        if (e_cm[CM_TXND]) begin
          obj_ctl_r[e_idx][CTL_NEW_DATA_FLAG] <= 1'b0;
        end
      end
    end else if (act_data || act_rst) begin
      // header always stored; standard frames clear the low id bits
      obj_arb_r[sc_idx_r][28:0] <= f_xtd_r ? f_id_r : {f_id_r[28:STD_LO], 18'h0};
      obj_arb_r[sc_idx_r][ARB_XTD] <= f_xtd_r;
      obj_ctl_r[sc_idx_r][3:0] <= f_dlc_r;
      obj_ctl_r[sc_idx_r][CTL_NEW_DATA_FLAG] <= 1'b1;
      obj_ctl_r[sc_idx_r][CTL_TRANSMIT_REQUEST] <= 1'b0;
      if (obj_ctl_r[sc_idx_r][CTL_NEW_DATA_FLAG]) begin
        obj_ctl_r[sc_idx_r][CTL_MESSAGE_LOST] <= 1'b1;
      end
      if (act_data) begin
        obj_dat_r[sc_idx_r] <= f_data_r;
        if (obj_ctl_r[sc_idx_r][CTL_RX_IRQ_ENABLE]) begin
          obj_ctl_r[sc_idx_r][CTL_IRQ_PENDING] <= 1'b1;
        end
      end
    end else if (act_ans) begin
      obj_ctl_r[sc_idx_r][CTL_TRANSMIT_REQUEST] <= 1'b1;
    end else if (gnt_txl) begin
      obj_ctl_r[tx_sel][CTL_NEW_DATA_FLAG] <= 1'b0;
    end
  end

  // receive scan: one object per granted cycle; frames arriving mid-scan are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_st_r <= SC_IDLE;
      sc_idx_r <= 5'h00;
      f_id_r <= 29'h0;
      f_xtd_r <= 1'b0;
      f_rtr_r <= 1'b0;
      f_dlc_r <= 4'h0;
      f_data_r <= RST_DAT;
    end else begin
      case (scan_st_r)
        SC_IDLE: begin
          if (rx_valid) begin
            f_id_r <= rx_id;
            f_xtd_r <= rx_xtd;
            f_rtr_r <= rx_rtr;
            f_dlc_r <= rx_dlc;
            f_data_r <= rx_data;
            sc_idx_r <= 5'h00;
            scan_st_r <= SC_RUN;
          end
        end
        SC_RUN: begin
          if (gnt_scan) begin
            if (hit || (sc_idx_r == 5'(NOBJ - 1))) begin
              scan_st_r <= SC_IDLE;
            end else begin
              sc_idx_r <= sc_idx_r + 5'h01;
            end
          end
        end
        default: scan_st_r <= SC_IDLE;
      endcase
    end
  end

  // transmit load and completion capture; a completion is never lost to a grant clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_pend_r <= 1'b0;
      tx_load_r <= 1'b0;
      txobj_r <= 5'h00;
      tx_id <= 29'h0;
      tx_xtd <= 1'b0;
      tx_rtr <= 1'b0;
      tx_dlc <= 4'h0;
      tx_data <= RST_DAT;
    end else begin
      txd_pend_r <= tx_done || (txd_pend_r && !gnt_txd);
      tx_load_r <= gnt_txl;
      if (gnt_txl) begin
        txobj_r <= tx_sel;
        tx_id <= obj_arb_r[tx_sel][28:0];
        tx_xtd <= obj_arb_r[tx_sel][ARB_XTD];
        tx_rtr <= !obj_arb_r[tx_sel][ARB_DIR];
        tx_dlc <= obj_ctl_r[tx_sel][3:0];
        tx_data <= obj_dat_r[tx_sel];
      end
    end
  end
  assign tx_load = tx_load_r;
  assign tx_obj = txobj_r;

  // apb read data captured in the setup cycle
  always_comb begin
    rd_val = 32'h0000_0000;
    case (paddr)
      OFF_CMSK, OFF_CMSK + IF_BASE2: rd_val = {24'h0, cmsk_r[paddr[6]]};
      OFF_CRQ, OFF_CRQ + IF_BASE2: rd_val = {16'h0, busy_r[paddr[6]], 9'h0, crq_r[paddr[6]]};
      OFF_MSK, OFF_MSK + IF_BASE2: rd_val = msk_r[paddr[6]];
      OFF_ARB, OFF_ARB + IF_BASE2: rd_val = arb_r[paddr[6]];
      OFF_MCTL, OFF_MCTL + IF_BASE2: rd_val = {16'h0, ctl_r[paddr[6]]};
      OFF_DA, OFF_DA + IF_BASE2: rd_val = da_r[paddr[6]];
      OFF_DB, OFF_DB + IF_BASE2: rd_val = db_r[paddr[6]];
      OFF_TXRQ: rd_val = pend_vec;
      OFF_NEW_DATA_FLAG: rd_val = new_data_flag_vec;
      OFF_IRQ_PENDING: rd_val = irq_pending_vec;
      OFF_VALID: rd_val = valid_vec;
      default: rd_val = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= rd_val;
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rx_take;
    rx_valid && (scan_st_r == SC_IDLE);
  endsequence
  sequence s_rd_all;
    gnt_if[0] && (cmsk_r[0] == CMSK_RD_ALL) && crq_ok[0];
  endsequence
  property p_serial;
    $onehot0({gnt_txd, gnt_if, gnt_scan, gnt_txl});
  endproperty
  a_serial: assert property (p_serial) else $error("two memory users in one cycle");
  property p_prio;
    gnt_txl |-> ((pend_vec & ((32'h1 << tx_sel) - 32'h1)) == 32'h0) && pend_vec[tx_sel];
  endproperty
  a_prio: assert property (p_prio) else $error("lower object left pending");
  property p_scan;
    s_rx_take |=> (scan_st_r == SC_RUN) ##[1:200] (scan_st_r == SC_IDLE);
  endproperty
  a_scan: assert property (p_scan) else $error("scan did not finish");
  property p_store;
    act_data |=> obj_ctl_r[$past(sc_idx_r)][CTL_NEW_DATA_FLAG] &&
      (obj_dat_r[$past(sc_idx_r)] == $past(f_data_r)) &&
      (obj_ctl_r[$past(sc_idx_r)][3:0] == $past(f_dlc_r)) &&
      !obj_ctl_r[$past(sc_idx_r)][CTL_TRANSMIT_REQUEST];
  endproperty
  a_store: assert property (p_store) else $error("data frame not stored");
  property p_lost;
    act_data && obj_ctl_r[sc_idx_r][CTL_NEW_DATA_FLAG] |=> obj_ctl_r[$past(sc_idx_r)][CTL_MESSAGE_LOST];
  endproperty
  a_lost: assert property (p_lost) else $error("message lost not raised");
  property p_rxirq;
    act_data && obj_ctl_r[sc_idx_r][CTL_RX_IRQ_ENABLE] |=> obj_ctl_r[$past(sc_idx_r)][CTL_IRQ_PENDING];
  endproperty
  a_rxirq: assert property (p_rxirq) else $error("receive pending not set");
  property p_std;
    act_data && !f_xtd_r |=> (obj_arb_r[$past(sc_idx_r)][STD_LO-1:0] == 18'h0);
  endproperty
  a_std: assert property (p_std) else $error("low id bits not cleared");
  property p_ans;
    act_ans |=> obj_ctl_r[$past(sc_idx_r)][CTL_TRANSMIT_REQUEST] &&
      (obj_arb_r[$past(sc_idx_r)] == $past(obj_arb_r[sc_idx_r])) &&
      (obj_dat_r[$past(sc_idx_r)] == $past(obj_dat_r[sc_idx_r]));
  endproperty
  a_ans: assert property (p_ans) else $error("remote answer changed object");
  property p_ign;
    act_ign |=> (obj_ctl_r[$past(sc_idx_r)] == $past(obj_ctl_r[sc_idx_r]));
  endproperty
  a_ign: assert property (p_ign) else $error("ignored remote frame left a trace");
  property p_rclr;
    act_rst |=> !obj_ctl_r[$past(sc_idx_r)][CTL_TRANSMIT_REQUEST] &&
      obj_ctl_r[$past(sc_idx_r)][CTL_NEW_DATA_FLAG] &&
      (obj_dat_r[$past(sc_idx_r)] == $past(obj_dat_r[sc_idx_r]));
  endproperty
  a_rclr: assert property (p_rclr) else $error("masked remote frame misstored");
  property p_txdone;
    gnt_txd && !obj_ctl_r[txobj_r][CTL_NEW_DATA_FLAG] && obj_ctl_r[txobj_r][CTL_TX_IRQ_ENABLE] |=>
      !obj_ctl_r[$past(txobj_r)][CTL_TRANSMIT_REQUEST] && obj_ctl_r[$past(txobj_r)][CTL_IRQ_PENDING];
  endproperty
  a_txdone: assert property (p_txdone) else $error("completion not recorded");
  property p_rdall;
    s_rd_all |=> !obj_ctl_r[$past(if_idx[0])][CTL_NEW_DATA_FLAG] &&
      !obj_ctl_r[$past(if_idx[0])][CTL_IRQ_PENDING];
  endproperty
  a_rdall: assert property (p_rdall) else $error("read did not acknowledge");
endmodule

//--- verification/can_message_object_handler_bench.sv
module can_message_object_handler_bench import cmoh_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, hold = 1;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rd, prdata, irq_pending_vec;
  logic pready, pslverr, rx_valid = 0, rx_xtd = 0, rx_rtr = 0, tx_free, tx_done, tx_load;
  logic tx_xtd, tx_rtr;
  logic [28:0] rx_id = '0, tx_id;
  logic [3:0] rx_dlc = '0, tx_dlc;
  logic [63:0] rx_data = '0, tx_data;
  logic [4:0] tx_obj, o;
  int n_fail = 0, total_checks = 0, cyc = 0;

  cmoh_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_id(rx_id), .rx_xtd(rx_xtd),
    .rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_data(rx_data), .tx_free(tx_free),
    .tx_done(tx_done), .tx_load(tx_load), .tx_id(tx_id), .tx_xtd(tx_xtd),
    .tx_rtr(tx_rtr), .tx_dlc(tx_dlc), .tx_data(tx_data), .tx_obj(tx_obj),
    .irq_pending_vec(irq_pending_vec));
  cmoh_can_model #(.LEN(20)) i_can (.pclk(pclk), .presetn(presetn), .tx_load(tx_load),
    .hold(hold), .tx_free(tx_free), .tx_done(tx_done));

  always #10 pclk = ~pclk;
  // hang guard: all tests fit well inside this many cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // command then object number, then poll busy under a bound
  task automatic xfer(input logic [11:0] b, input logic [7:0] cm, input logic [5:0] n);
    int k;
    apb(1'b1, b + OFF_CMSK, {24'h0, cm});
    apb(1'b1, b + OFF_CRQ, {26'h0, n});
    k = 0;
    do begin
      apb(1'b0, b + OFF_CRQ, 32'h0);
      k++;
    end while (rd[CRQ_BUSY] !== 1'b0 && k < 20);
    chk("busy", 32'h0, {31'h0, rd[CRQ_BUSY]});
  endtask
  task automatic cfg(input logic [5:0] n, input logic [31:0] arb, ctl, da, db);
    apb(1'b1, OFF_DA, da);
    apb(1'b1, OFF_DB, db);
    apb(1'b1, OFF_MCTL, ctl);
    apb(1'b1, OFF_ARB, arb);
    xfer(12'h000, 8'hf3, n);
  endtask
  // released frame fields are inverted so stale values never match
  task automatic rx_frame(input logic [28:0] id, input logic rtr, input logic [63:0] d);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_rtr <= rtr;
    rx_dlc <= 4'h8;
    rx_data <= d;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_id <= ~id;
    rx_rtr <= ~rtr;
    rx_dlc <= 4'h7;
    rx_data <= ~d;
    rx_xtd <= 1'b1;
    repeat (40) @(posedge pclk);
    rx_xtd <= 1'b0;
  endtask
  task automatic wait_load(output logic [4:0] ob);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      #1;
      k++;
    end while (tx_load !== 1'b1 && k < 300);
    chk("tx_load", 32'h1, {31'h0, tx_load});
    ob = tx_obj;
  endtask

  task automatic t_reset;
    apb(1'b0, OFF_CRQ, 32'h0);
    chk("crq", 32'h1, rd);
    apb(1'b0, OFF_MSK, 32'h0);
    chk("msk", RST_MSK, rd);
    apb(1'b1, 12'h0fc, 32'h1);
    chk("slverr", 32'h1, {31'h0, err});
    $display("test reset done");
  endtask
  // two requests queued behind a busy line, higher id in the lower object
  task automatic t_prio;
    cfg(6'd3, 32'ha004_0000, 32'h0000_0188, 32'h0, 32'h0);
    cfg(6'd2, 32'hbffc_0000, 32'h0000_0988, 32'h0302_0100, 32'h0706_0504);
    hold <= 1'b0;
    wait_load(o);
    chk("first obj", 32'h1, {27'h0, o});
    chk("tx id", 32'h1ffc_0000, {3'h0, tx_id});
    chk("tx data", 32'h0302_0100, tx_data[31:0]);
    chk("tx dlc", 32'h8, {28'h0, tx_dlc});
    chk("tx xtd", 32'h0, {31'h0, tx_xtd});
    wait_load(o);
    chk("second obj", 32'h2, {27'h0, o});
    repeat (40) @(posedge pclk);
    chk("irq vec", 32'h2, irq_pending_vec);
    apb(1'b0, OFF_TXRQ, 32'h0);
    chk("txrq vec", 32'h0, rd);
    $display("test priority done");
  endtask
  task automatic t_rx;
    cfg(6'd5, 32'h848c_0000, 32'h0000_0488, 32'h0, 32'h0);
    rx_frame(29'h048c_0155, 1'b0, 64'h1122_3344_5566_7788);
    chk("rx irq", 32'h12, irq_pending_vec);
    rx_frame(29'h048c_0155, 1'b0, 64'h1122_3344_5566_7788);
    xfer(IF_BASE2, CMSK_RD_ALL, 6'd5);
    apb(1'b0, IF_BASE2 + OFF_ARB, 32'h0);
    chk("rx arb", 32'h848c_0000, rd);
    apb(1'b0, IF_BASE2 + OFF_MCTL, 32'h0);
    chk("rx ctl", 32'h0000_e488, rd);
    apb(1'b0, IF_BASE2 + OFF_DA, 32'h0);
    chk("rx da", 32'h5566_7788, rd);
    apb(1'b0, IF_BASE2 + OFF_DB, 32'h0);
    chk("rx db", 32'h1122_3344, rd);
    apb(1'b0, OFF_NEW_DATA_FLAG, 32'h0);
    chk("new_data_flag vec", 32'h0, rd);
    chk("irq cleared", 32'h2, irq_pending_vec);
    xfer(IF_BASE2, CMSK_RD_ALL, 6'd5);
    apb(1'b0, IF_BASE2 + OFF_MCTL, 32'h0);
    chk("lost kept", 32'h0000_4488, rd);
    $display("test receive done");
  endtask
  task automatic t_remote;
    cfg(6'd7, 32'ha154_0000, 32'h0000_0284, 32'hcafe_0001, 32'h0);
    cfg(6'd8, 32'ha198_0000, 32'h0000_0084, 32'h0, 32'h0);
    rx_frame(29'h0198_0000, 1'b1, 64'h0);
    apb(1'b0, OFF_TXRQ, 32'h0);
    chk("ignored", 32'h0, rd);
    fork
      rx_frame(29'h0154_0000, 1'b1, 64'h0);
      wait_load(o);
    join
    chk("answer obj", 32'h6, {27'h0, o});
    chk("answer kind", 32'h0, {31'h0, tx_rtr});
    chk("answer data", 32'hcafe_0001, tx_data[31:0]);
    $display("test remote done");
  endtask

  // group mask on a receive and a transmit object, then a data-only update
  task automatic t_mask;
    hold <= 1'b1;
    apb(1'b1, OFF_MSK, 32'h5f00_0000);
    cfg(6'd10, 32'h8a00_0000, 32'h0000_1188, 32'h0, 32'h0);
    cfg(6'd11, 32'hab00_0000, 32'h0000_1184, 32'h1234_5678, 32'h0);
    rx_frame(29'h0a34_0000, 1'b0, 64'h0);
    rx_frame(29'h0b44_0000, 1'b1, 64'h0);
    apb(1'b0, OFF_TXRQ, 32'h0);
    chk("txrq masked", 32'h0, rd);
    xfer(12'h000, CMSK_RD_ALL, 6'd10);
    apb(1'b0, OFF_ARB, 32'h0);
    chk("masked arb", 32'h8a34_0000, rd);
    apb(1'b0, OFF_NEW_DATA_FLAG, 32'h0);
    chk("rmt new_data_flag", 32'h400, rd);
    apb(1'b1, OFF_DA, 32'h0bad_0002);
    apb(1'b1, OFF_DB, 32'h0);
    xfer(12'h000, 8'h87, 6'd11);
    hold <= 1'b0;
    wait_load(o);
    chk("upd obj", 32'ha, {27'h0, o});
    chk("upd data", 32'h0bad_0002, tx_data[31:0]);
    $display("test mask done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_prio();
    t_rx();
    t_remote();
    t_mask();
    tally_and_finish();
  end
endmodule

//--- verification/cmoh_can_model.sv
module cmoh_can_model #(
  parameter int LEN = 20
) (
  input wire logic pclk, // module clock
  input wire logic presetn, // async reset, active low
  input wire logic tx_load, // frame handed over
  input wire logic hold, // keep the shift register busy
  output logic tx_free, // shift register may be loaded
  output logic tx_done // frame sent ok
);
  int cnt;
  // one frame in flight; hold lets the bench pile up requests first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_free <= 1'b0;
      tx_done <= 1'b0;
      cnt <= 0;
    end else begin
      tx_done <= 1'b0;
      if (tx_load) begin
        tx_free <= 1'b0; // dropped at once, or the handler reloads
        cnt <= LEN;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (cnt == 1) begin
        cnt <= 0;
        tx_done <= 1'b1;
      end else begin
        tx_free <= !hold;
      end
    end
  end
endmodule
